// ==== rtl/sampling_conversion_power_ctrl.sv ====
`timescale 1ns/10ps
module sampling_conversion_power_ctrl #(
  parameter int SHUTDOWN_WAKE = conv_ctrl_pkg::SHUTDOWN_CYCLES
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Host pins, asynchronous
  input  wire logic                  sample_start_a,
  input  wire logic                  sample_start_b,
  input  wire logic                  power_down_n,
  input  wire logic                  rangeHigh,
  // Converter side
  output logic                       busy,
  output logic [7:0]                 holdMask,
  output logic                       convStart,
  output logic                       resultsReady,
  output logic                       coreOn,
  output logic                       refOn,
  output conv_ctrl_pkg::status_t     status
);
  import conv_ctrl_pkg::*;

  // Delay from busy rise to the last busy cycle, for the length check.
  localparam int CONV_LAST = CONV_CYCLES - 1;

  pins_t            pinsRaw;
  pins_t            pins;
  pwr_t             pwrState;
  logic             pwrReady;
  logic             startA_q;
  logic             startB_q;
  logic             riseA;
  logic             riseB;
  logic             armA_q;
  logic             armB_q;
  logic             busy_q;
  logic [7:0]       hold_q;
  logic [CNT_W-1:0] conv_q;
  logic             ready_q;
  logic             bothArmed;
  logic             busyFall;

  assign pinsRaw = '{sampleStartA: sample_start_a, sampleStartB: sample_start_b,
                     powerDownN: power_down_n, rangeHigh: rangeHigh};

  pin_sync u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pinsIn  (pinsRaw),
    .pinsOut (pins)
  );

  power_ctrl #(
    .STANDBY_WAKE  (STANDBY_CYCLES),
    .SHUTDOWN_WAKE (SHUTDOWN_WAKE)
  ) u_pwr (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .powerDownN (pins.powerDownN),
    .rangeHigh  (pins.rangeHigh),
    .pwrState   (pwrState),
    .ready      (pwrReady)
  );

  // =====================================================
  // Edge detection on synchronised start inputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      startA_q <= 1'b0;
      startB_q <= 1'b0;
    end else begin
      startA_q <= pins.sampleStartA;
      startB_q <= pins.sampleStartB;
    end
  end

  // Edges are ignored while busy or not powered; the host must not send them then.
  assign riseA     = pins.sampleStartA && !startA_q && pwrReady && !busy_q;
  assign riseB     = pins.sampleStartB && !startB_q && pwrReady && !busy_q;
  assign bothArmed = (armA_q || riseA) && (armB_q || riseB);
  assign busyFall  = busy_q && (conv_q == CNT_W'(1));

  // =====================================================
  // Track-and-hold control per channel half
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= HOLD_NONE;
    end else if (busyFall) begin
      hold_q <= HOLD_NONE;
    end else if (!pwrReady && !busy_q) begin
      // A half held before power-down would otherwise stay held with no conversion behind it.
      hold_q <= HOLD_NONE;
    end else begin
      if (riseA) begin
        hold_q <= hold_q | HOLD_LOWER | (riseB ? HOLD_UPPER : HOLD_NONE);
      end else if (riseB) begin
        hold_q <= hold_q | HOLD_UPPER;
      end
    end
  end

  // =====================================================
  // Arming: each start arms its half until both have come
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      armA_q <= 1'b0;
      armB_q <= 1'b0;
    end else if (bothArmed || !pwrReady) begin
      armA_q <= 1'b0;
      armB_q <= 1'b0;
    end else begin
      armA_q <= armA_q | riseA;
      armB_q <= armB_q | riseB;
    end
  end

  // =====================================================
  // Conversion timer; all channels always converted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      conv_q <= '0;
    end else if (bothArmed) begin
      busy_q <= 1'b1;
      conv_q <= CNT_W'(CONV_CYCLES);
    end else if (busy_q) begin
      conv_q <= conv_q - CNT_W'(1);
      if (busyFall) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Results flag: cleared at start, set at busy fall; old data stays valid meanwhile.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else if (busyFall) begin
      ready_q <= 1'b1;
    end else if (bothArmed) begin
      ready_q <= 1'b0;
    end
  end

  // =====================================================
  // Outputs
  assign busy         = busy_q;
  assign holdMask     = hold_q;
  assign convStart    = bothArmed;
  assign resultsReady = ready_q;
  assign coreOn       = (pwrState == PWR_NORMAL) || (pwrState == PWR_WAKING);
  assign refOn        = (pwrState != PWR_SHUTDOWN);
  assign status       = '{busy: busy_q, holdMask: hold_q, resultsReady: ready_q,
                          coreOn: coreOn, refOn: refOn};

  // =====================================================
  // Checks
  sequence convRun_s;
    busy_q [*8];
  endsequence

  busy_length_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(busy_q) |-> ##CONV_LAST busy_q ##1 !busy_q)
    else $error("busy length wrong");
  busy_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(busy_q) |-> convRun_s)
    else $error("busy dropped early");
  track_return_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(busy_q) |-> hold_q == HOLD_NONE)
    else $error("hold not released");
  ready_on_fall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(busy_q) |-> ready_q)
    else $error("results not flagged");
  common_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (riseA && riseB) |=> hold_q == (HOLD_LOWER | HOLD_UPPER) && busy_q)
    else $error("common start not simultaneous");
  lower_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (riseA && !riseB && !armB_q) |=> hold_q == HOLD_LOWER && !busy_q)
    else $error("lower half not held alone");
  later_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (armA_q && riseB) |=> $rose(busy_q))
    else $error("busy not on later edge");
  old_data_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    busy_q |-> !ready_q)
    else $error("ready during busy");
  upper_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (riseB && !riseA && !armA_q) |=> hold_q == HOLD_UPPER && !busy_q)
    else $error("upper half not held alone");
  earlier_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (armB_q && riseA) |=> $rose(busy_q))
    else $error("busy not on later A edge");
  no_restart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (busy_q && !busyFall) |=> busy_q && conv_q == $past(conv_q) - CNT_W'(1))
    else $error("conversion timer disturbed");
  idle_refuse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !pwrReady |-> !convStart)
    else $error("start taken in low power");
  pending_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!pwrReady && !busy_q) |=> hold_q == HOLD_NONE && !armA_q && !armB_q)
    else $error("pending hold kept in low power");
endmodule

// ==== inc/conv_ctrl_pkg.sv ====
// Notes on behaviour
// - Power-down low: range high standby, low shutdown.
// - Power-down pin high means normal operation.
// - Standby keeps reference; wake takes 100 us.
// - Shutdown powers all off; wake takes 13 ms.
// - Common start edge holds every channel together.
// - Busy high for one conversion time interval.
// - Busy falling edge returns all holds to track.
// - Busy fall marks new results readable.
// - Start A holds lower half, B upper.
// - Conversion and busy start on later edge.
// - Readout sequence same for tied or split.
// - All channels converted and included in readout.
// - Eight channels convert in 4 us total.
// - During busy, previous results stay readable.
package conv_ctrl_pkg;

  // =====================================================
  // Sizes and timing
  localparam int          CHANNELS          = 8;
  localparam int          HALF              = CHANNELS / 2;
  localparam int          CLK_HZ            = 20_000_000;
  localparam int          CONV_TIME_NS      = 4000;
  localparam int          STANDBY_WAKE_US   = 100;
  localparam int          SHUTDOWN_WAKE_MS  = 13;
  // Longest times round down, with no floor of one cycle.
  localparam int          CONV_CYCLES       = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          STANDBY_CYCLES    = STANDBY_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int          SHUTDOWN_CYCLES   = SHUTDOWN_WAKE_MS * (CLK_HZ / 1000);
  localparam int          CNT_W             = 20;
  localparam logic [7:0]  HOLD_NONE         = 8'h00;
  localparam logic [7:0]  HOLD_LOWER        = 8'h0f;
  localparam logic [7:0]  HOLD_UPPER        = 8'hf0;

  // =====================================================
  // Types
  typedef enum logic [1:0] {PWR_NORMAL, PWR_STANDBY, PWR_SHUTDOWN, PWR_WAKING} pwr_t;

  typedef struct packed {
    logic sampleStartA;
    logic sampleStartB;
    logic powerDownN;
    logic rangeHigh;
  } pins_t;

  // Synchroniser reset values match the idle pin levels, so no false power-down follows reset.
  localparam pins_t       PINS_IDLE         = '{sampleStartA: 1'b0, sampleStartB: 1'b0,
                                                powerDownN: 1'b1, rangeHigh: 1'b0};

  typedef struct packed {
    logic       busy;
    logic [7:0] holdMask;
    logic       resultsReady;
    logic       coreOn;
    logic       refOn;
  } status_t;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // Pins
  input  wire conv_ctrl_pkg::pins_t pinsIn,
  output conv_ctrl_pkg::pins_t       pinsOut
);
  import conv_ctrl_pkg::*;

  pins_t meta_q;

  // =====================================================
  // Two-stage synchroniser; first stage feeds only the second.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= PINS_IDLE;
      pinsOut <= PINS_IDLE;
    end else begin
      meta_q  <= pinsIn;
      pinsOut <= meta_q;
    end
  end
endmodule

// ==== rtl/power_ctrl.sv ====
`timescale 1ns/10ps
module power_ctrl #(
  parameter int STANDBY_WAKE   = conv_ctrl_pkg::STANDBY_CYCLES,
  parameter int SHUTDOWN_WAKE  = conv_ctrl_pkg::SHUTDOWN_CYCLES
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Synchronised pins
  input  wire logic                  powerDownN,
  input  wire logic                  rangeHigh,
  // State
  output conv_ctrl_pkg::pwr_t        pwrState,
  output logic                       ready
);
  import conv_ctrl_pkg::*;

  pwr_t             state_q;
  logic [CNT_W-1:0] wait_q;

  assign pwrState = state_q;
  assign ready    = (state_q == PWR_NORMAL);

  // =====================================================
  // Power states and wake-up timing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PWR_NORMAL;
      wait_q  <= '0;
    end else begin
      case (state_q)
        PWR_NORMAL, PWR_WAKING: begin
          if (!powerDownN) begin
            state_q <= rangeHigh ? PWR_STANDBY : PWR_SHUTDOWN;
          end else if (state_q == PWR_WAKING) begin
            if (wait_q <= CNT_W'(1)) begin
              state_q <= PWR_NORMAL;
            end
            wait_q <= wait_q - CNT_W'(1);
          end
        end
        PWR_STANDBY: begin
          if (powerDownN) begin
            state_q <= PWR_WAKING;
            wait_q  <= CNT_W'(STANDBY_WAKE);
          end
        end
        PWR_SHUTDOWN: begin
          if (powerDownN) begin
            state_q <= PWR_WAKING;
            wait_q  <= CNT_W'(SHUTDOWN_WAKE);
          end
        end
        default: state_q <= PWR_NORMAL;
      endcase
    end
  end

  standby_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ready && !powerDownN && rangeHigh) |=> state_q == PWR_STANDBY)
    else $error("standby not entered");
  shutdown_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ready && !powerDownN && !rangeHigh) |=> state_q == PWR_SHUTDOWN)
    else $error("shutdown not entered");
  standby_wake_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWR_STANDBY && powerDownN) |=>
      (state_q == PWR_WAKING && wait_q == CNT_W'(STANDBY_WAKE)))
    else $error("standby wake time wrong");
  shutdown_wake_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWR_SHUTDOWN && powerDownN) |=>
      (state_q == PWR_WAKING && wait_q == CNT_W'(SHUTDOWN_WAKE)))
    else $error("shutdown wake time wrong");
  wake_done_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWR_WAKING && powerDownN && wait_q <= CNT_W'(1)) |=> ready)
    else $error("normal operation not resumed");
endmodule

// ==== bench/conv_host_model.sv ====
`timescale 1ns/10ps
module conv_host_model (
  // Clock
  input  wire logic sys_clk,
  // Pins toward the device
  output logic      resetn,
  output logic      sample_start_a,
  output logic      sample_start_b,
  output logic      power_down_n,
  output logic      rangeHigh
);
  // =====================================================
  // Power-up
  // Reset once supplies are up so the pin configuration is adopted.
  initial begin
    resetn = 1'b0;
    sample_start_a = 1'b0;
    sample_start_b = 1'b0;
    power_down_n = 1'b1;
    rangeHigh = 1'b1;
    repeat (4) @(posedge sys_clk);
    #5 resetn = 1'b1;
  end

  // =====================================================
  // Pin control
  // Callers only act just after a rising edge; no oversampling, skew kept small.
  task automatic set_start(input bit a, input bit b);
    sample_start_a = a;
    sample_start_b = b;
  endtask

  task automatic set_power(input bit pd, input bit rng);
    power_down_n = pd;
    rangeHigh = rng;
  endtask

  // Only called once the full wake interval after shutdown has passed.
  task automatic pulse_reset();
    resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #5 resetn = 1'b1;
  endtask
endmodule

// ==== bench/tb_sampling_conversion_power_ctrl.sv ====
`timescale 1ns/10ps
module tb_sampling_conversion_power_ctrl;
  import conv_ctrl_pkg::*;
  localparam int SD_WAKE = 50;
  // Two synchroniser stages and the busy register before busy rises.
  localparam int START_LAT = 3;
  logic       sys_clk = 1'b0;
  logic       convStart;
  status_t    status;
  wire        resetn, sample_start_a, sample_start_b, power_down_n, rangeHigh;
  logic       busy, resultsReady, coreOn, refOn;
  logic [7:0] holdMask;
  int         error_cnt, total_checks;

  always #25 sys_clk = ~sys_clk;

  conv_host_model u_host (.sys_clk(sys_clk), .resetn(resetn), .sample_start_a(sample_start_a),
    .sample_start_b(sample_start_b), .power_down_n(power_down_n), .rangeHigh(rangeHigh));

  sampling_conversion_power_ctrl #(.SHUTDOWN_WAKE(SD_WAKE)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .sample_start_a(sample_start_a), .sample_start_b(sample_start_b), .power_down_n(power_down_n),
    .rangeHigh(rangeHigh), .busy(busy), .holdMask(holdMask), .convStart(convStart), .resultsReady(resultsReady),
    .coreOn(coreOn), .refOn(refOn), .status(status));

  // =====================================================
  // Reporting
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic checkn(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // A lone A edge holds the lower half, a lone B edge the upper half.
  function automatic logic [7:0] first_half(input bit aFirst);
    return aFirst ? HOLD_LOWER : HOLD_UPPER;
  endfunction

  // Outputs come only from registers, so 5 ns after the edge they are settled.
  task automatic tick();
    @(posedge sys_clk);
    #5;
  endtask

  // =====================================================
  // Conversion, tied or split starts, optional start during busy
  task automatic run_conv(input bit aFirst, input int skew, input bit retrig);
    int n;
    int starts;
    tick();
    if (skew == 0) u_host.set_start(1'b1, 1'b1);
    else u_host.set_start(aFirst, !aFirst);
    if (skew > 0) begin
      repeat (skew) tick();
      check8(holdMask, first_half(aFirst), "half hold");
      check8(busy, 1'b0, "busy before second start");
      u_host.set_start(1'b1, 1'b1);
    end
    starts = 0;
    for (n = 0; n < 10 && busy !== 1'b1; n++) begin
      if (convStart === 1'b1) starts++;
      tick();
    end
    checkn(n, START_LAT, "busy rise latency");
    checkn(starts, 1, "one conversion start");
    if (n >= 10) finish_test();
    check8(holdMask, 8'hff, "all held");
    check8(status.holdMask, HOLD_LOWER | HOLD_UPPER, "status holds");
    check8({status.busy, status.resultsReady, status.coreOn, status.refOn}, 8'h0b, "status flags");
    check8(resultsReady, 1'b0, "ready cleared at start");
    u_host.set_start(1'b0, 1'b0);
    for (n = 1; n < 300; n++) begin
      tick();
      if (retrig && n == 20) u_host.set_start(1'b1, 1'b1);
      if (retrig && n == 24) u_host.set_start(1'b0, 1'b0);
      if (busy !== 1'b1) break;
    end
    checkn(n, CONV_CYCLES, "busy length");
    if (n >= 300) finish_test();
    check8(holdMask, HOLD_NONE, "back to track");
    check8(resultsReady, 1'b1, "results ready");
    repeat (8) tick();
    check8(busy, 1'b0, "start during busy ignored");
  endtask

  // =====================================================
  // Low-power entry, refusal of starts, wake-up
  task automatic power_test(input bit rng, input int wake);
    tick();
    u_host.set_power(1'b0, rng);
    repeat (6) tick();
    check8(coreOn, 1'b0, "core off");
    check8(refOn, rng, "reference state");
    u_host.set_start(1'b1, 1'b1);
    repeat (8) tick();
    check8(busy, 1'b0, "start in low power");
    u_host.set_start(1'b0, 1'b0);
    u_host.set_power(1'b1, rng);
    tick();
    u_host.set_start(1'b1, 1'b1);
    repeat (8) tick();
    check8(busy, 1'b0, "start while waking");
    u_host.set_start(1'b0, 1'b0);
    repeat (wake) tick();
    if (!rng) u_host.pulse_reset();
    check8({coreOn, refOn}, 8'h03, "normal again");
    run_conv(1'b1, 0, 1'b0);
    $display("Power test range %0d done", rng);
  endtask

  // =====================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(82));
    repeat (6) tick();
    check8({busy, resultsReady, coreOn, refOn}, 8'h03, "reset flags");
    check8(holdMask, HOLD_NONE, "reset holds");
    $display("Reset test done");
    run_conv(1'b1, 0, 1'b0);
    run_conv(1'b1, 0, 1'b1);
    run_conv(1'b1, 6, 1'b0);
    run_conv(1'b0, 6, 1'b1);
    $display("Directed conversion tests done");
    for (int i = 0; i < 6; i++) begin
      run_conv($urandom % 2, ($urandom % 2) ? 0 : 5 + $urandom % 16, $urandom % 2);
    end
    $display("Random conversion tests done");
    power_test(1'b1, STANDBY_CYCLES);
    power_test(1'b0, SD_WAKE);
    finish_test();
  end
endmodule
